// [hdl/sadcpd_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sadcpd_defs.svh"

module sadcpd_top
	import sadcpd_pkg::*;
#(
	parameter int          RES_BITS       = `SADCPD_RES_BITS_DEF,
	parameter int unsigned REF_SETTLE_CYC = `SADCPD_REF_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Serial port pins, sampled synchronously
	input  wire logic                convert_strobe,
	input  wire logic                shift_clk,
	// Result pin, three-state
	output logic                     result_out,
	output logic                     result_oe_n,
	// Analog core
	input  wire logic                comp_in,
	output logic [RES_BITS-1:0]      dac_trial,
	output logic                     sample_hold,
	output logic                     core_power_on,
	output logic                     ref_power_on,
	// Status
	output logic                     ref_settled,
	output logic                     convert_strobe_busy,
	output logic                     pwr_nap,
	output logic                     pwr_sleep
);

	localparam int SETTLE_W = $clog2(REF_SETTLE_CYC + 1);

	// The frame has room for two lead edges plus the result
	if (RES_BITS < 2 || RES_BITS > 14) begin : g_bad_res
		$error("sadcpd_top: RES_BITS must lie in 2..14");
	end
	if (REF_SETTLE_CYC < 1) begin : g_bad_settle
		$error("sadcpd_top: REF_SETTLE_CYC must be at least 1");
	end

	localparam logic [4:0] LAST_DATA_EDGE = 5'(RES_BITS + 2); // R15
	localparam logic [4:0] LAST_SAR_EDGE  = 5'(RES_BITS + 1);

	// Edge detection on the sampled pins
	logic convert_strobe_prev_q;
	logic sck_prev_q;
	logic convert_strobe_rise;
	logic sck_rise;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			convert_strobe_prev_q <= 1'b0;
			sck_prev_q  <= 1'b0;
		end else begin
			convert_strobe_prev_q <= convert_strobe;
			sck_prev_q  <= shift_clk;
		end
	end

	assign convert_strobe_rise = convert_strobe & ~convert_strobe_prev_q;
	assign sck_rise  = shift_clk & ~sck_prev_q;

	// Power state
	sadcpd_pwr_t pwr_q;

	sadcpd_standby u_standby (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.convert_strobe_rise (convert_strobe_rise),
		.sck_rise  (sck_rise),
		.pwr_q     (pwr_q)
	);

	// Conversion framing
	sadcpd_convert_strobe_t convert_strobe_q;
	sadcpd_convert_strobe_t convert_strobe_d;
	logic [4:0]   edge_cnt_q;
	logic [4:0]   edge_cnt_d;
	logic         oe_n_q;
	logic         oe_n_d;
	logic         bit_q;
	logic         bit_d;
	logic         sar_clear;
	logic         sar_step;
	logic [3:0]   sar_idx;
	logic [RES_BITS-1:0] code;

	always_comb begin
		int sel;
		sel        = 0;
		convert_strobe_d     = convert_strobe_q;
		edge_cnt_d = edge_cnt_q;
		oe_n_d     = oe_n_q;
		bit_d      = bit_q;
		sar_clear  = 1'b0;
		sar_step   = 1'b0;
		sar_idx    = 4'h0;
		case (convert_strobe_q)
			SADCPD_CONVERT_STROBE_TRACK: begin
				if (convert_strobe_rise) begin
					// Start: sample is held, approximation restarts
					convert_strobe_d     = SADCPD_CONVERT_STROBE_BUSY; // R7
					edge_cnt_d = 5'h00;
					sar_clear  = 1'b1;
					oe_n_d     = 1'b1; // R16
				end else if (sck_rise) begin
					// Seventeenth edge of a full-width frame releases the pin
					oe_n_d = 1'b1; // R17
				end
			end
			SADCPD_CONVERT_STROBE_BUSY: begin
				// Strobes are ignored here until the frame's edges are done
				if (sck_rise) begin // R7
					edge_cnt_d = edge_cnt_q + 5'h01;
					if (edge_cnt_d >= `SADCPD_FIRST_SAR_EDGE &&
					    edge_cnt_d <= LAST_SAR_EDGE) begin
						sar_step = 1'b1; // R12
						sar_idx  = 4'(edge_cnt_d - `SADCPD_FIRST_SAR_EDGE);
					end
					if (edge_cnt_d >= `SADCPD_FIRST_DATA_EDGE &&
					    edge_cnt_d <= LAST_DATA_EDGE) begin
						// Bit decided one edge earlier is launched now, MSB first
						sel    = int'(LAST_DATA_EDGE) - int'(edge_cnt_d); // R13
						bit_d  = code[sel]; // R12
						oe_n_d = 1'b0; // R10
					end else begin
						oe_n_d = 1'b1; // R17
					end
					if (edge_cnt_d == `SADCPD_FRAME_EDGES) begin
						convert_strobe_d = SADCPD_CONVERT_STROBE_TRACK; // R7
					end
				end
			end
			default: begin
				convert_strobe_d     = SADCPD_CONVERT_STROBE_TRACK;
				edge_cnt_d = 5'h00;
				oe_n_d     = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			convert_strobe_q     <= SADCPD_CONVERT_STROBE_TRACK; // R1
			edge_cnt_q <= 5'h00;
			oe_n_q     <= 1'b1; // R16
			bit_q      <= 1'b0;
		end else begin
			convert_strobe_q     <= convert_strobe_d;
			edge_cnt_q <= edge_cnt_d;
			oe_n_q     <= oe_n_d;
			bit_q      <= bit_d;
		end
	end

	sadcpd_sar #(
		.RES_BITS (RES_BITS)
	) u_sar (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.clear    (sar_clear),
		.step     (sar_step),
		.step_idx (sar_idx),
		.busy     (convert_strobe_q == SADCPD_CONVERT_STROBE_BUSY),
		.comp_in  (comp_in),
		.trial    (dac_trial),
		.code_q   (code)
	);

	// Reference settling after deep standby; the block only reports it
	logic [SETTLE_W-1:0] settle_cnt_q;
	logic [SETTLE_W-1:0] settle_cnt_d;

	always_comb begin
		settle_cnt_d = settle_cnt_q;
		if (pwr_q == SADCPD_PWR_SLEEP) begin
			settle_cnt_d = SETTLE_W'(REF_SETTLE_CYC);
		end else if (settle_cnt_q != '0) begin
			settle_cnt_d = settle_cnt_q - SETTLE_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			settle_cnt_q <= '0;
		end else begin
			settle_cnt_q <= settle_cnt_d;
		end
	end

	// Outputs
	assign result_out    = bit_q; // R18
	assign result_oe_n   = oe_n_q; // R17
	assign sample_hold   = (convert_strobe_q == SADCPD_CONVERT_STROBE_BUSY);
	assign convert_strobe_busy     = (convert_strobe_q == SADCPD_CONVERT_STROBE_BUSY);
	assign core_power_on = (pwr_q == SADCPD_PWR_ACTIVE);
	assign ref_power_on  = (pwr_q != SADCPD_PWR_SLEEP); // R3
	assign ref_settled   = (settle_cnt_q == '0) && ref_power_on;
	assign pwr_nap       = (pwr_q == SADCPD_PWR_NAP);
	assign pwr_sleep     = (pwr_q == SADCPD_PWR_SLEEP);

endmodule
`default_nettype wire

// [pkg/sadcpd_defs.svh]
// What this block and its controller do
// [R1] Power-up leaves converter active and ready
// [R2] Two strobes, no clock edge: light standby
// [R3] Light standby keeps reference powered
// [R4] Clock edge wakes; next strobe converts accurately
// [R5] Four strobes, no clock edge: deep standby
// [R6] Controller waits 2ms after deep wake; the controller model converts at once and the block only reports ref_settled
// [R7] Strobe starts conversion; others ignored sixteen edges
// [R8] Controller gives seventeen edges between strobes
// [R9] One extra period gives 39ns acquisition
// [R10] Whole result leaves within sixteen clock periods
// [R11] Controller keeps strobe low over 15ns
// [R12] Each clock edge advances approximation and output
// [R13] Result MSB first from third edge
// [R14] Receiver captures bits on falling edge
// [R15] Fourteen-bit result right justified in sixteen
// [R16] Output high impedance from power-up until conversion
// [R17] Output high impedance unless sending result bits
// [R18] Bit valid before the next clock edge
// [R19] Natural binary result coding
// [R20] Any clock edge clears strobe count
`ifndef SADCPD_DEFS_SVH
`define SADCPD_DEFS_SVH

`define SADCPD_RES_BITS_DEF     14
`define SADCPD_FRAME_EDGES      5'h10
`define SADCPD_FIRST_DATA_EDGE  5'h03
`define SADCPD_FIRST_SAR_EDGE   5'h02
`define SADCPD_NAP_STROBES      3'h2
`define SADCPD_SLEEP_STROBES    3'h4
`define SADCPD_CLK_PERIOD_PS    8000
`define SADCPD_REF_SETTLE_NS    2000000
`define SADCPD_REF_SETTLE_CYC   ((`SADCPD_REF_SETTLE_NS * 1000) / `SADCPD_CLK_PERIOD_PS)

`endif

// [pkg/sadcpd_pkg.sv]
package sadcpd_pkg;

	typedef enum logic [2:0] {
		SADCPD_PWR_ACTIVE = 3'h1,
		SADCPD_PWR_NAP    = 3'h2,
		SADCPD_PWR_SLEEP  = 3'h4
	} sadcpd_pwr_t;

	typedef enum logic [1:0] {
		SADCPD_CONVERT_STROBE_TRACK = 2'h1,
		SADCPD_CONVERT_STROBE_BUSY  = 2'h2
	} sadcpd_convert_strobe_t;

endpackage

// [hdl/sadcpd_standby.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sadcpd_defs.svh"

module sadcpd_standby
	import sadcpd_pkg::*;
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  sys_rst,
	// Edge events
	input  wire logic  convert_strobe_rise,
	input  wire logic  sck_rise,
	// Power state
	output sadcpd_pwr_t pwr_q
);

	logic [2:0]  strobe_cnt_q;
	logic [2:0]  strobe_cnt_d;
	sadcpd_pwr_t pwr_d;

	always_comb begin
		strobe_cnt_d = strobe_cnt_q;
		pwr_d        = pwr_q;
		if (sck_rise) begin
			// A strobe in the same cycle as a clock edge counts as the first of a run
			strobe_cnt_d = convert_strobe_rise ? 3'h1 : 3'h0; // R20
			pwr_d        = SADCPD_PWR_ACTIVE; // R4
		end else if (convert_strobe_rise && strobe_cnt_q != `SADCPD_SLEEP_STROBES) begin
			strobe_cnt_d = strobe_cnt_q + 3'h1;
		end
		if (!sck_rise) begin
			case (strobe_cnt_d)
				`SADCPD_NAP_STROBES: begin
					if (pwr_q == SADCPD_PWR_ACTIVE) begin
						pwr_d = SADCPD_PWR_NAP; // R2
					end
				end
				`SADCPD_SLEEP_STROBES: begin
					pwr_d = SADCPD_PWR_SLEEP; // R5
				end
				default: begin
					pwr_d = pwr_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strobe_cnt_q <= 3'h0;
			pwr_q        <= SADCPD_PWR_ACTIVE; // R1
		end else begin
			strobe_cnt_q <= strobe_cnt_d;
			pwr_q        <= pwr_d;
		end
	end

endmodule
`default_nettype wire

// [hdl/sadcpd_sar.sv]
`timescale 1ns/1ps
`default_nettype none

module sadcpd_sar
	import sadcpd_pkg::*;
#(
	parameter int RES_BITS = 14
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Control
	input  wire logic                clear,
	input  wire logic                step,
	input  wire logic [3:0]          step_idx,
	input  wire logic                busy,
	// Comparator
	input  wire logic                comp_in,
	output logic [RES_BITS-1:0]      trial,
	// Result
	output logic [RES_BITS-1:0]      code_q
);

	logic [RES_BITS-1:0] code_d;

	// The step index is four bits wide, so sixteen bits at most
	if (RES_BITS < 1 || RES_BITS > 16) begin : g_bad_res
		$error("sadcpd_sar: RES_BITS must lie in 1..16");
	end

	// Index 0 is the MSB; a high comparator keeps the trial bit, giving plain binary
	for (genvar i = 0; i < RES_BITS; i++) begin : g_bit
		localparam logic [3:0] IDX = 4'(RES_BITS - 1 - i);
		always_comb begin
			code_d[i] = code_q[i];
			trial[i]  = code_q[i] | (busy && step_idx == IDX); // R19
			if (clear) begin
				code_d[i] = 1'b0;
			end else if (step && step_idx == IDX) begin
				code_d[i] = comp_in; // R12
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			code_q <= '0;
		end else begin
			code_q <= code_d;
		end
	end

endmodule
`default_nettype wire

// [testbench/sadcpd_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module sadcpd_properties (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Pins
	input  wire logic convert_strobe,
	input  wire logic shift_clk,
	input  wire logic result_out,
	input  wire logic result_oe_n,
	// Status
	input  wire logic core_power_on,
	input  wire logic ref_power_on,
	input  wire logic convert_strobe_busy,
	input  wire logic pwr_nap,
	input  wire logic pwr_sleep
);
	logic       sck_q, sck_d, con_q, con_d, sck_r, con_r;
	logic [2:0] cnt_q, cnt_d;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Count saturates so a long strobe train never wraps back to nap
	always_comb begin
		sck_r = shift_clk & ~sck_q;
		con_r = convert_strobe & ~con_q;
		sck_d = shift_clk;
		con_d = convert_strobe;
		cnt_d = cnt_q;
		if (sck_r) cnt_d = {2'h0, con_r};
		else if (con_r && cnt_q != 3'h4) cnt_d = cnt_q + 3'h1;
	end
	always_ff @(posedge clk) begin
		sck_q <= sys_rst ? 1'b0 : sck_d;
		con_q <= sys_rst ? 1'b0 : con_d;
		cnt_q <= sys_rst ? 3'h0 : cnt_d;
	end
	property p_hiz;
		$past(sys_rst) |-> result_oe_n;
	endproperty
	a_hiz: assert property (p_hiz) else $error("pin driven after reset");
	property p_nap;
		con_r && !sck_r && cnt_q == 3'h1 |=> pwr_nap;
	endproperty
	a_nap: assert property (p_nap) else $error("no light standby");
	property p_sleep;
		con_r && !sck_r && cnt_q == 3'h3 |=> pwr_sleep;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no deep standby");
	property p_wake;
		sck_r |=> !pwr_nap && !pwr_sleep;
	endproperty
	a_wake: assert property (p_wake) else $error("clock edge did not wake");
	property p_ref;
		pwr_nap || pwr_sleep |-> ref_power_on == pwr_nap && !core_power_on;
	endproperty
	a_ref: assert property (p_ref) else $error("standby power wrong");
	property p_drive;
		$fell(result_oe_n) |-> convert_strobe_busy && $past(sck_r);
	endproperty
	a_drive: assert property (p_drive) else $error("pin driven off frame");
	property p_hold;
		!result_oe_n && !$past(sck_r) |-> $stable(result_out);
	endproperty
	a_hold: assert property (p_hold) else $error("bit changed early");
	property p_start;
		con_r && !convert_strobe_busy |=> convert_strobe_busy;
	endproperty
	a_start: assert property (p_start) else $error("strobe did not start");
endmodule

`default_nettype wire

// [testbench/sadcpd_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

module sadcpd_ctrl_model (
	// Clock
	input  wire logic clk,
	// Result pin
	input  wire logic result_out,
	input  wire logic result_oe_n,
	// Controls
	output var logic  convert_strobe,
	output var logic  shift_clk
);
	logic sdo_w;
	// Released pin shows the inverse so a stale bit never passes
	assign sdo_w = result_oe_n ? ~result_out : result_out;
	initial begin
		convert_strobe = 1'b0;
		shift_clk = 1'b0;
	end
	task automatic strobe();
		@(negedge clk);
		convert_strobe = 1'b1;
		repeat (2) @(negedge clk);
		convert_strobe = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic pulse(input bit mid, input bit cap, inout logic [15:0] w);
		shift_clk = 1'b1;
		convert_strobe = mid;
		repeat (2) @(negedge clk);
		shift_clk = 1'b0;
		convert_strobe = 1'b0;
		if (cap) w = {w[14:0], sdo_w};
		repeat (2) @(negedge clk);
	endtask
	task automatic frame(input bit go, input int n, input int mid, output logic [15:0] w);
		w = 16'h0000;
		if (go) strobe();
		for (int i = 1; i <= n; i++) pulse(i == mid, i <= 16, w);
	endtask
endmodule

`default_nettype wire

// [testbench/test_serial_adc_port_power_down.sv]
`timescale 1ns/1ps
`default_nettype none

module test_serial_adc_port_power_down;
	localparam int REF_CYC = 100;
	logic        clk, sys_rst, comp_in, convert_strobe, shift_clk;
	logic        result_out, result_oe_n, sample_hold, core_power_on;
	logic        ref_power_on, ref_settled, convert_strobe_busy, pwr_nap, pwr_sleep;
	logic [13:0] dac_trial, ain;
	logic [15:0] w;
	int          err_total, compares;
	assign comp_in = (dac_trial <= ain);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	sadcpd_top #(.RES_BITS(14), .REF_SETTLE_CYC(REF_CYC)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .convert_strobe(convert_strobe),
		.shift_clk(shift_clk), .result_out(result_out), .result_oe_n(result_oe_n),
		.comp_in(comp_in), .dac_trial(dac_trial), .sample_hold(sample_hold),
		.core_power_on(core_power_on), .ref_power_on(ref_power_on),
		.ref_settled(ref_settled), .convert_strobe_busy(convert_strobe_busy), .pwr_nap(pwr_nap),
		.pwr_sleep(pwr_sleep));
	sadcpd_ctrl_model i_ctl (.clk(clk), .result_out(result_out),
		.result_oe_n(result_oe_n), .convert_strobe(convert_strobe), .shift_clk(shift_clk));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic t_reset();
		chk(16'(result_oe_n), 16'h0001);
		chk(16'({pwr_nap, pwr_sleep, core_power_on}), 16'h0001);
		$display("test reset done");
	endtask
	task automatic t_convert_strobe();
		logic [13:0] v[4];
		v = '{14'h3FFF, 14'h0000, 14'h2AC5, 14'h1555};
		foreach (v[i]) begin
			ain = v[i];
			i_ctl.frame(1'b1, 17, 0, w);
			chk(w & 16'h3FFF, {2'h0, v[i]});
			chk(16'(result_oe_n), 16'h0001);
			chk(16'({sample_hold, convert_strobe_busy}), 16'h0000);
		end
		$display("test convert_strobe done");
	endtask
	task automatic t_ignore();
		ain = 14'h1234;
		i_ctl.frame(1'b1, 18, 8, w);
		chk(w & 16'h3FFF, 16'h1234);
		$display("test ignore done");
	endtask
	task automatic t_count();
		i_ctl.strobe();
		i_ctl.frame(1'b0, 1, 0, w);
		i_ctl.strobe();
		chk(16'({pwr_nap, core_power_on}), 16'h0001);
		i_ctl.frame(1'b0, 17, 0, w);
		chk(16'(result_oe_n), 16'h0001);
		$display("test count done");
	endtask
	task automatic t_nap();
		ain = 14'h0F0F;
		i_ctl.strobe();
		i_ctl.strobe();
		chk(16'({pwr_nap, ref_power_on, core_power_on}), 16'h0006);
		chk(16'({sample_hold, convert_strobe_busy}), 16'h0003);
		i_ctl.frame(1'b0, 17, 0, w);
		chk(16'({pwr_nap, core_power_on}), 16'h0001);
		chk(w & 16'h3FFF, 16'h0F0F);
		$display("test nap done");
	endtask
	task automatic t_sleep();
		ain = 14'h2001;
		repeat (4) i_ctl.strobe();
		chk(16'({pwr_sleep, ref_power_on, ref_settled}), 16'h0004);
		i_ctl.frame(1'b0, 17, 0, w);
		chk(16'({pwr_sleep, ref_settled}), 16'h0000);
		repeat (50) @(negedge clk);
		chk(16'(ref_settled), 16'h0001);
		chk(w & 16'h3FFF, 16'h2001);
		$display("test sleep done");
	endtask
	// Whole run is under a thousand cycles; the limit leaves a wide margin
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
	initial begin
		sys_rst = 1'b1;
		ain = 14'h0000;
		err_total = 0;
		compares = 0;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_convert_strobe();
		t_ignore();
		t_count();
		t_nap();
		t_sleep();
		end_sim();
	end
endmodule

bind sadcpd_top sadcpd_properties i_props (.clk(clk), .sys_rst(sys_rst),
	.convert_strobe(convert_strobe), .shift_clk(shift_clk), .result_out(result_out),
	.result_oe_n(result_oe_n), .core_power_on(core_power_on), .ref_power_on(ref_power_on),
	.convert_strobe_busy(convert_strobe_busy), .pwr_nap(pwr_nap), .pwr_sleep(pwr_sleep));

`default_nettype wire
